//--- asq_pkg.sv
/*
 * Constants, register map and types of the two-axis step sequencer.
 * Assumes a single 200 MHz clock and a byte-addressed Avalon-MM slave.
 */
package asq_pkg;

  localparam int ASQ_AXES   = 2;
  localparam int ASQ_STEP_W = 8;
  localparam int ASQ_DEPTH  = 256;
  localparam int ASQ_VAL_W  = 16;
  localparam int ASQ_DW     = 32;
  localparam int ASQ_AW     = 8;

  // Register byte offsets; per-axis registers sit one word apart.
  localparam logic [7:0] ASQ_OFS_CMD_BASE  = 8'h00;
  localparam logic [7:0] ASQ_OFS_STAT_BASE = 8'h08;
  localparam logic [7:0] ASQ_AXIS_STRIDE   = 8'h04;
  localparam logic [7:0] ASQ_OFS_IRQ_ST    = 8'h10;
  localparam logic [7:0] ASQ_OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0] ASQ_OFS_TBL_ADDR  = 8'h18;
  localparam logic [7:0] ASQ_OFS_TBL_DATA  = 8'h1C;

  // Command register layout.
  localparam int ASQ_CMD_VAL_LSB  = 0;
  localparam int ASQ_CMD_CODE_LSB = 16;

  // Command codes.
  localparam logic [7:0] ASQ_CMD_EVENT  = 8'h45;
  localparam logic [7:0] ASQ_CMD_HALT   = 8'h48;
  localparam logic [7:0] ASQ_CMD_QUIT   = 8'h51;
  localparam logic [7:0] ASQ_CMD_KILL   = 8'h4B;
  localparam logic [7:0] ASQ_CMD_UPDATE = 8'h55;
  localparam logic [15:0] ASQ_FLASH_ARG = 16'h0002;

  // Step table entry layout.
  localparam int ASQ_ENT_NEXT_LSB = 0;
  localparam int ASQ_ENT_KIND_LSB = 8;
  localparam int ASQ_ENT_KIND_W   = 4;
  localparam int ASQ_ENT_CMD_BIT  = 12;
  localparam int ASQ_ENT_VAL_LSB  = 16;

  localparam logic [3:0] ASQ_LK_END    = 4'h0;
  localparam logic [3:0] ASQ_LK_STATUS = 4'h1;
  localparam logic [3:0] ASQ_LK_DELAY  = 4'h2;

  // Axis status register layout.
  localparam int ASQ_ST_STEP_LSB  = 0;
  localparam int ASQ_ST_RUN_BIT   = 8;
  localparam int ASQ_ST_ACK_BIT   = 9;
  localparam int ASQ_ST_ESTOP_BIT = 10;

  // Interrupt bits.
  localparam int ASQ_IRQ_END_LSB   = 0;
  localparam int ASQ_IRQ_FOK_BIT   = 2;
  localparam int ASQ_IRQ_FFAIL_BIT = 3;
  localparam int ASQ_IRQ_W         = 4;

  // Control tick timing.
  localparam int ASQ_CLK_PERIOD_PS = 5000;
  localparam int ASQ_TICK_US       = 1000;
  localparam int ASQ_TICK_CYC =
    (ASQ_TICK_US * 1000000) / ASQ_CLK_PERIOD_PS;

  typedef enum logic [3:0] {
    ASQ_SQ_IDLE  = 4'b0001,
    ASQ_SQ_ENTER = 4'b0010,
    ASQ_SQ_WAIT  = 4'b0100,
    ASQ_SQ_ARMED = 4'b1000
  } asq_state_t;

endpackage : asq_pkg

//--- asq_tick.sv
/*
 * Control tick generator: one-cycle pulse every CYCLES clocks.
 * Assumes the sequencer clock and its clock enable.
 */
`timescale 1ns/1ps
module asq_tick #(
  parameter int CYCLES = 200000
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Tick.
  output logic      tick_o
);
  import asq_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt_r == LAST) begin
        cnt_r  <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + CW'(1);
        tick_o <= 1'b0;
      end
    end
  end

endmodule : asq_tick

//--- asq_top.sv
/*
 * Two-axis step sequencer with Avalon-MM register slave and interrupt.
 * Assumes axis status words and the flash engine run on clk_i.
 */
`timescale 1ns/1ps
module asq_top #(
  parameter int TICK_CYCLES = asq_pkg::ASQ_TICK_CYC
) (
  // Clock, reset, enable.
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         ce_i,
  // Avalon-MM slave.
  input  wire logic [asq_pkg::ASQ_AW-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [asq_pkg::ASQ_DW-1:0]   avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [asq_pkg::ASQ_DW-1:0]   avs_readdata_o,
  output logic                              avs_waitrequest_o,
  // Interrupt.
  output logic                              irq_o,
  // Axis status words from the motion loops.
  input  wire logic [1:0][15:0]             axis_status_i,
  // Commands toward the motion loops.
  output logic      [1:0]                   step_cmd_valid_o,
  output logic      [1:0][7:0]              step_cmd_step_o,
  output logic      [1:0]                   host_cmd_valid_o,
  output logic      [7:0]                   host_cmd_code_o,
  output logic      [15:0]                  host_cmd_value_o,
  output logic      [1:0]                   estop_o,
  // Flash save engine.
  output logic                              flash_save_req_o,
  input  wire logic                         flash_done_i,
  input  wire logic                         flash_ok_i
);
  import asq_pkg::*;

  localparam int SW = ASQ_STEP_W;
  localparam int VW = ASQ_VAL_W;

  // Merges write data into an old value under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [3:0] ent_kind(input logic [31:0] e);
    return e[ASQ_ENT_KIND_LSB +: ASQ_ENT_KIND_W];
  endfunction : ent_kind

  function automatic logic [VW-1:0] ent_val(input logic [31:0] e);
    return e[ASQ_ENT_VAL_LSB +: VW];
  endfunction : ent_val

  // Evaluates the one link condition of a step.
  function automatic logic link_met(input logic [31:0]   e,
                                    input logic [15:0]   st,
                                    input logic [VW-1:0] ticks);
    logic r;
    r = 1'b0;
    case (ent_kind(e))
      ASQ_LK_STATUS: r = |(st & ent_val(e));
      ASQ_LK_DELAY:  r = (ticks >= ent_val(e));
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : link_met

  // Bus state.
  logic                 wait_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rd_nxt;
  logic                 acc;
  logic                 wr_acc;
  logic [7:0]           addr;

  // Registers.
  logic [31:0]          table_r [ASQ_DEPTH];
  logic [SW-1:0]        tbl_addr_r;
  logic [ASQ_IRQ_W-1:0] irq_st_r;
  logic [ASQ_IRQ_W-1:0] irq_mask_r;
  logic [ASQ_IRQ_W-1:0] irq_set;
  logic                 irq_r;

  // Host command decode.
  logic [1:0]           cmd_wr;
  logic [7:0]           hcode;
  logic [VW-1:0]        hval;
  logic [1:0]           host_cmd;
  logic                 upd_cmd;

  // Sequencer state per axis.
  asq_state_t           state_r [ASQ_AXES];
  logic [1:0][SW-1:0]   step_r;
  logic [1:0][VW-1:0]   dcnt_r;
  logic [31:0]          entry   [ASQ_AXES];
  logic [1:0]           seq_end;
  logic [1:0]           estop_r;
  logic [1:0]           step_v_r;
  logic [1:0][SW-1:0]   step_s_r;
  logic [1:0]           host_v_r;
  logic [7:0]           host_c_r;
  logic [VW-1:0]        host_d_r;

  // Flash save and control tick.
  logic                 fbusy_r;
  logic                 freq_r;
  logic [1:0]           ack_r;
  logic                 tick;

  asq_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .tick_o  (tick)
  );

  // A request is taken at the edge where waitrequest is seen low.
  assign addr   = avs_address_i;
  assign acc    = (avs_read_i || avs_write_i) && !wait_r;
  assign wr_acc = avs_write_i && !wait_r;
  assign hcode  = avs_writedata_i[ASQ_CMD_CODE_LSB +: 8];
  assign hval   = avs_writedata_i[ASQ_CMD_VAL_LSB +: VW];

  always_comb begin
    upd_cmd = 1'b0;
    for (int a = 0; a < ASQ_AXES; a++) begin
      cmd_wr[a] = wr_acc && (addr == 8'(ASQ_OFS_CMD_BASE
                             + ASQ_AXIS_STRIDE * a));
      host_cmd[a] = cmd_wr[a] && (hcode != ASQ_CMD_UPDATE);
      if (cmd_wr[a] && hcode == ASQ_CMD_UPDATE
          && hval == ASQ_FLASH_ARG) begin
        upd_cmd = 1'b1;
      end
    end
  end

  // Waitrequest drops for one cycle per request, readdata with it.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_r  <= 1'b1;
      rdata_r <= '0;
    end else if (ce_i) begin
      if ((avs_read_i || avs_write_i) && wait_r) begin
        wait_r  <= 1'b0;
        rdata_r <= avs_read_i ? rd_nxt : '0;
      end else begin
        wait_r  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_nxt = '0;
    for (int a = 0; a < ASQ_AXES; a++) begin
      if (addr == 8'(ASQ_OFS_STAT_BASE + ASQ_AXIS_STRIDE * a)) begin
        rd_nxt[ASQ_ST_STEP_LSB +: SW] = step_r[a];
        rd_nxt[ASQ_ST_RUN_BIT]        = (state_r[a] != ASQ_SQ_IDLE);
        rd_nxt[ASQ_ST_ACK_BIT]        = ack_r[a];
        rd_nxt[ASQ_ST_ESTOP_BIT]      = estop_r[a];
      end
    end
    case (addr)
      ASQ_OFS_IRQ_ST:   rd_nxt[ASQ_IRQ_W-1:0] = irq_st_r;
      ASQ_OFS_IRQ_MASK: rd_nxt[ASQ_IRQ_W-1:0] = irq_mask_r;
      ASQ_OFS_TBL_ADDR: rd_nxt[SW-1:0]        = tbl_addr_r;
      ASQ_OFS_TBL_DATA: rd_nxt                = table_r[tbl_addr_r];
      default:          rd_nxt                = rd_nxt;
    endcase
  end

  // Step table storage and its address pointer.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tbl_addr_r <= '0;
      for (int i = 0; i < ASQ_DEPTH; i++) begin
        table_r[i] <= '0;
      end
    end else if (ce_i && wr_acc) begin
      if (addr == ASQ_OFS_TBL_ADDR) begin
        tbl_addr_r <= SW'(be_merge(32'(tbl_addr_r), avs_writedata_i,
                                   avs_byteenable_i));
      end
      if (addr == ASQ_OFS_TBL_DATA) begin
        table_r[tbl_addr_r] <= be_merge(table_r[tbl_addr_r],
                                        avs_writedata_i,
                                        avs_byteenable_i);
      end
    end
  end

  // Interrupt status, mask and output; a new event beats the clear.
  always_comb begin
    irq_set = '0;
    for (int a = 0; a < ASQ_AXES; a++) begin
      irq_set[ASQ_IRQ_END_LSB + a] = seq_end[a];
    end
    irq_set[ASQ_IRQ_FOK_BIT]   = fbusy_r && flash_done_i && flash_ok_i;
    irq_set[ASQ_IRQ_FFAIL_BIT] = fbusy_r && flash_done_i && !flash_ok_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_st_r   <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
    end else if (ce_i) begin
      if (wr_acc && addr == ASQ_OFS_IRQ_ST && avs_byteenable_i[0]) begin
        irq_st_r <= (irq_st_r & ~avs_writedata_i[ASQ_IRQ_W-1:0])
                    | irq_set;
      end else begin
        irq_st_r <= irq_st_r | irq_set;
      end
      if (wr_acc && addr == ASQ_OFS_IRQ_MASK && avs_byteenable_i[0]) begin
        irq_mask_r <= avs_writedata_i[ASQ_IRQ_W-1:0];
      end
      irq_r <= |(irq_st_r & irq_mask_r);
    end
  end

  // Flash save: acks clear at request and set only on completion.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fbusy_r <= 1'b0;
      freq_r  <= 1'b0;
      ack_r   <= '0;
    end else if (ce_i) begin
      freq_r <= 1'b0;
      if (!fbusy_r && upd_cmd) begin
        fbusy_r <= 1'b1;
        freq_r  <= 1'b1;
        ack_r   <= '0;
      end else if (fbusy_r && flash_done_i) begin
        fbusy_r  <= 1'b0;
        ack_r[0] <= flash_ok_i;
        ack_r[1] <= !flash_ok_i;
      end
    end
  end

  // Host command forwarding; step commands yield to host commands.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      host_v_r <= '0;
      host_c_r <= '0;
      host_d_r <= '0;
      estop_r  <= '0;
    end else if (ce_i) begin
      for (int a = 0; a < ASQ_AXES; a++) begin
        host_v_r[a] <= host_cmd[a] && hcode != ASQ_CMD_EVENT;
        if (host_cmd[a]) begin
          estop_r[a] <= (hcode == ASQ_CMD_KILL);
        end
      end
      if (|host_cmd) begin
        host_c_r <= hcode;
        host_d_r <= hval;
      end
    end
  end

  // Each axis runs its own sequence over the shared table.
  for (genvar g = 0; g < ASQ_AXES; g++) begin : g_axis
    logic [VW-1:0] dcnt_inc;

    assign entry[g]   = table_r[step_r[g]];
    assign dcnt_inc   = (dcnt_r[g] == '1) ? dcnt_r[g]
                                          : dcnt_r[g] + VW'(1);
    assign seq_end[g] = !host_cmd[g] && state_r[g] == ASQ_SQ_ENTER
                        && ent_kind(entry[g]) == ASQ_LK_END;

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        state_r[g] <= ASQ_SQ_IDLE;
        step_r[g]  <= '0;
        dcnt_r[g]  <= '0;
      end else if (ce_i) begin
        if (host_cmd[g]) begin
          if (hcode == ASQ_CMD_EVENT) begin
            state_r[g] <= ASQ_SQ_ENTER;
            step_r[g]  <= hval[SW-1:0];
          end else begin
            state_r[g] <= ASQ_SQ_IDLE;
            step_r[g]  <= '0;
          end
        end else begin
          case (state_r[g])
            ASQ_SQ_IDLE: begin
              step_r[g] <= '0;
            end
            ASQ_SQ_ENTER: begin
              dcnt_r[g] <= '0;
              if (ent_kind(entry[g]) == ASQ_LK_END) begin
                state_r[g] <= ASQ_SQ_IDLE;
                step_r[g]  <= '0;
              end else if (link_met(entry[g], axis_status_i[g],
                                    '0)) begin
                state_r[g] <= ASQ_SQ_ARMED;
              end else begin
                state_r[g] <= ASQ_SQ_WAIT;
              end
            end
            ASQ_SQ_WAIT: begin
              if (tick) begin
                dcnt_r[g] <= dcnt_inc;
                if (link_met(entry[g], axis_status_i[g],
                             dcnt_inc)) begin
                  state_r[g] <= ASQ_SQ_ARMED;
                end
              end
            end
            ASQ_SQ_ARMED: begin
              if (tick) begin
                step_r[g]  <= entry[g][ASQ_ENT_NEXT_LSB +: SW];
                state_r[g] <= ASQ_SQ_ENTER;
              end
            end
            default: begin
              state_r[g] <= ASQ_SQ_IDLE;
              step_r[g]  <= '0;
            end
          endcase
        end
      end
    end

    // Step command is registered on the entry cycle of a step and goes out one cycle later.
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        step_v_r[g] <= 1'b0;
        step_s_r[g] <= '0;
      end else if (ce_i) begin
        step_v_r[g] <= !host_cmd[g] && state_r[g] == ASQ_SQ_ENTER
                       && entry[g][ASQ_ENT_CMD_BIT];
        step_s_r[g] <= step_r[g];
      end
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign irq_o             = irq_r;
  assign step_cmd_valid_o  = step_v_r;
  assign step_cmd_step_o   = step_s_r;
  assign host_cmd_valid_o  = host_v_r;
  assign host_cmd_code_o   = host_c_r;
  assign host_cmd_value_o  = host_d_r;
  assign estop_o           = estop_r;
  assign flash_save_req_o  = freq_r;

endmodule : asq_top

//--- asq_top_assertions.sv
/*
 * Checker of the step sequencer ports, bound into asq_top.
 * Assumes one clock, synchronous active-low reset, ce_i held high.
 */
`timescale 1ns/1ps
module asq_top_chk
  import asq_pkg::*;
(
  // Clock, reset, enable.
  input wire logic                       clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       ce_i,
  // Register bus.
  input wire logic [asq_pkg::ASQ_AW-1:0] avs_address_i,
  input wire logic                       avs_read_i,
  input wire logic                       avs_write_i,
  input wire logic [asq_pkg::ASQ_DW-1:0] avs_writedata_i,
  input wire logic                       avs_waitrequest_o,
  // Axis and flash side.
  input wire logic [1:0]                 host_cmd_valid_o,
  input wire logic [7:0]                 host_cmd_code_o,
  input wire logic [1:0]                 step_cmd_valid_o,
  input wire logic [1:0][7:0]            step_cmd_step_o,
  input wire logic [1:0]                 estop_o,
  input wire logic                       flash_save_req_o,
  input wire logic                       flash_done_i
);
  import asq_pkg::*;
  logic       busy_r;
  logic       tk;
  logic [7:0] code;
  assign tk   = ce_i && avs_write_i && !avs_waitrequest_o;
  assign code = avs_writedata_i[23:16];
  // A save request while one is pending is ignored by design.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || flash_done_i) begin
      busy_r <= 1'b0;
    end else if (flash_save_req_o) begin
      busy_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_wait_ans;
    ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("bus request not answered after one cycle");
  property p_wait_one;
    ce_i && !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low longer than one cycle");
  property p_flash_req;
    tk && avs_address_i == ASQ_OFS_CMD_BASE && code == ASQ_CMD_UPDATE
      && avs_writedata_i[15:0] == ASQ_FLASH_ARG && !busy_r
      |=> flash_save_req_o;
  endproperty
  a_flash_req: assert property (p_flash_req)
    else $error("save command did not request a flash save");
  property p_flash_one;
    flash_save_req_o |=> !flash_save_req_o [*3];
  endproperty
  a_flash_one: assert property (p_flash_one)
    else $error("flash save requested twice");
  property p_host_fwd;
    tk && avs_address_i == 8'h04 && code != ASQ_CMD_EVENT
      && code != ASQ_CMD_UPDATE
      |=> host_cmd_valid_o == 2'b10 && host_cmd_code_o == $past(code);
  endproperty
  a_host_fwd: assert property (p_host_fwd)
    else $error("host command not forwarded to axis two");
  property p_kill;
    tk && avs_address_i == 8'h04 && code == ASQ_CMD_KILL |=> estop_o[1];
  endproperty
  a_kill: assert property (p_kill)
    else $error("kill did not raise emergency stop");
  property p_unkill;
    tk && avs_address_i == 8'h04 && code != ASQ_CMD_KILL
      && code != ASQ_CMD_UPDATE && code != ASQ_CMD_EVENT |=> !estop_o[1];
  endproperty
  a_unkill: assert property (p_unkill)
    else $error("host command left emergency stop set");
  property p_step_cmd;
    tk && avs_address_i == ASQ_OFS_CMD_BASE && code == ASQ_CMD_EVENT
      |-> ##2 (!step_cmd_valid_o[0]
      || step_cmd_step_o[0] == $past(avs_writedata_i[7:0], 2));
  endproperty
  a_step_cmd: assert property (p_step_cmd)
    else $error("step command not from the requested step");
endmodule : asq_top_chk

bind asq_top asq_top_chk u_chk (
  .clk_i, .rst_n_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_waitrequest_o, .host_cmd_valid_o,
  .host_cmd_code_o, .step_cmd_valid_o, .step_cmd_step_o, .estop_o,
  .flash_save_req_o, .flash_done_i
);

//--- asq_flash_model.sv
/*
 * Flash save engine model answering the sequencer's save requests.
 * Assumes the sequencer clock; delay and outcome come from the bench.
 */
`timescale 1ns/1ps
module asq_flash_model (
  // Clock.
  input  wire logic clk_i,
  // Save handshake.
  input  wire logic req_i,
  input  wire logic ok_i,
  input  wire logic [31:0] dly_i,
  output logic      done_o,
  output logic      ok_o
);
  int   cnt = 0;
  logic tog = 1'b0;
  initial begin
    done_o = 1'b0;
    ok_o   = 1'b0;
  end
  // The result holds only beside done; elsewhere it keeps toggling.
  always @(posedge clk_i) begin
    tog    <= !tog;
    done_o <= 1'b0;
    ok_o   <= tog;
    if (req_i) begin
      cnt <= dly_i;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      ok_o   <= ok_i;
      cnt    <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : asq_flash_model

//--- asq_tb_top.sv
/*
 * Self-checking bench of the step sequencer with a flash engine model.
 * Assumes asq_pkg, asq_top, the checker and asq_flash_model compiled.
 */
`timescale 1ns/1ps
module asq_tb_top;
  import asq_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             ce_i = 1'b1;
  logic [15:0]      host_cmd_value_o;
  logic [7:0]       avs_address_i = 8'h00;
  logic             avs_read_i = 1'b0;
  logic             avs_write_i = 1'b0;
  logic [31:0]      avs_writedata_i = 32'h0;
  logic [1:0][15:0] axis_status_i = '0;
  logic [31:0]      avs_readdata_o, q;
  logic             avs_waitrequest_o, irq_o, flash_save_req_o;
  logic             flash_done_i, flash_ok_i, fok;
  logic [1:0]       step_cmd_valid_o, host_cmd_valid_o, estop_o;
  logic [1:0][7:0]  step_cmd_step_o;
  logic [7:0]       host_cmd_code_o, seen0, seen1;
  int               failures = 0, compares = 0, nreq = 0, nhost = 0;
  int               fdly = 20;

  always #2.5 clk_i = !clk_i;

  asq_top #(.TICK_CYCLES(20)) dut (
    .clk_i, .rst_n_i, .ce_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
    .avs_readdata_o, .avs_waitrequest_o, .irq_o, .axis_status_i,
    .step_cmd_valid_o, .step_cmd_step_o, .host_cmd_valid_o,
    .host_cmd_code_o, .host_cmd_value_o, .estop_o, .flash_save_req_o,
    .flash_done_i, .flash_ok_i
  );
  asq_flash_model u_flash (.clk_i, .req_i(flash_save_req_o), .ok_i(fok),
    .dly_i(fdly), .done_o(flash_done_i), .ok_o(flash_ok_i));

  always @(posedge clk_i) begin
    if (flash_save_req_o === 1'b1) nreq <= nreq + 1;
    if (host_cmd_valid_o[1] === 1'b1) nhost <= nhost + 1;
    if (step_cmd_valid_o[0] === 1'b1) seen0 <= step_cmd_step_o[0];
    if (step_cmd_valid_o[1] === 1'b1) seen1 <= step_cmd_step_o[1];
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic cmd(input int ax, input logic [7:0] c, input int v);
    bus(1'b1, 8'(ax * 4), {8'h00, c, 16'(v)});
  endtask : cmd

  task automatic stat(input int ax, input string nm, input int e);
    bus(1'b0, ASQ_OFS_STAT_BASE + 8'(ax * 4), 32'h0);
    chk(nm, 32'(e), 32'(q[8:0]));
  endtask : stat

  task automatic put(input logic [7:0] i, input logic [31:0] e);
    bus(1'b1, ASQ_OFS_TBL_ADDR, 32'(i));
    bus(1'b1, ASQ_OFS_TBL_DATA, e);
    bus(1'b0, ASQ_OFS_TBL_DATA, 32'h0);
    chk("table entry", e, q);
  endtask : put

  task automatic s_regs();
    chk("irq idle", 32'h0, 32'(irq_o));
    bus(1'b1, ASQ_OFS_IRQ_MASK, 32'h0000000F);
    bus(1'b0, ASQ_OFS_IRQ_MASK, 32'h0);
    chk("irq mask", 32'h0000000F, q);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, ASQ_OFS_IRQ_MASK, 32'h0);
    put(8'h05, {16'h0002, 4'h1, ASQ_LK_DELAY, 8'h06});
    put(8'h06, {16'h0001, 4'h1, ASQ_LK_STATUS, 8'h07});
    put(8'h07, {16'h0000, 4'h1, ASQ_LK_END, 8'h00});
  endtask : s_regs

  task automatic s_flash();
    fok <= 1'b1;
    cmd(0, ASQ_CMD_UPDATE, 3);
    repeat (30) @(posedge clk_i);
    chk("save ignored", 32'h0, 32'(nreq));
    cmd(0, ASQ_CMD_UPDATE, 2);
    bus(1'b0, ASQ_OFS_STAT_BASE, 32'h0);
    chk("ack early", 32'h0, 32'(q[9]));
    repeat (30) @(posedge clk_i);
    chk("save count", 32'h1, 32'(nreq));
    bus(1'b0, ASQ_OFS_STAT_BASE, 32'h0);
    chk("ack axis1", 32'h1, 32'(q[9]));
    bus(1'b0, ASQ_OFS_STAT_BASE + 8'h04, 32'h0);
    chk("ack axis2", 32'h0, 32'(q[9]));
    chk("irq masked", 32'h0, 32'(irq_o));
    bus(1'b1, ASQ_OFS_IRQ_MASK, 32'h00000004);
    @(posedge clk_i);
    chk("irq raised", 32'h1, 32'(irq_o));
    bus(1'b1, ASQ_OFS_IRQ_ST, 32'h00000004);
    @(posedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    fdly <= 1;
    fok  <= 1'b0;
    cmd(0, ASQ_CMD_UPDATE, 2);
    repeat (10) @(posedge clk_i);
    bus(1'b0, ASQ_OFS_STAT_BASE, 32'h0);
    chk("fail axis1", 32'h0, 32'(q[9]));
    bus(1'b0, ASQ_OFS_STAT_BASE + 8'h04, 32'h0);
    chk("fail axis2", 32'h1, 32'(q[9]));
    bus(1'b0, ASQ_OFS_IRQ_ST, 32'h0);
    chk("irq fail", 32'h8, 32'(q[3:0]));
    bus(1'b1, ASQ_OFS_IRQ_ST, 32'h0000000F);
  endtask : s_flash

  task automatic s_chain();
    cmd(0, ASQ_CMD_EVENT, 5);
    stat(0, "step start", 32'h105);
    chk("cmd step", 32'h5, 32'(seen0));
    axis_status_i[0] <= 16'h0002;
    repeat (100) @(posedge clk_i);
    stat(0, "step wait", 32'h106);
    chk("cmd next", 32'h6, 32'(seen0));
    axis_status_i[0] <= 16'h0001;
    repeat (60) @(posedge clk_i);
    stat(0, "step end", 32'h0);
    chk("cmd last", 32'h7, 32'(seen0));
    bus(1'b0, ASQ_OFS_IRQ_ST, 32'h0);
    chk("end irq", 32'h1, 32'(q[0]));
  endtask : s_chain

  task automatic s_axes();
    axis_status_i <= '0;
    cmd(0, ASQ_CMD_EVENT, 6);
    cmd(1, ASQ_CMD_EVENT, 6);
    repeat (30) @(posedge clk_i);
    stat(0, "shared 1", 32'h106);
    stat(1, "shared 2", 32'h106);
    axis_status_i[0] <= 16'h0001;
    repeat (60) @(posedge clk_i);
    stat(0, "own 1", 32'h0);
    stat(1, "own 2", 32'h106);
    // With the clock enable low the met link must not be acted on.
    ce_i             <= 1'b0;
    axis_status_i[1] <= 16'h0001;
    repeat (60) @(posedge clk_i);
    ce_i <= 1'b1;
    stat(1, "frozen", 32'h106);
    axis_status_i <= '0;
    cmd(1, ASQ_CMD_EVENT, 5);
    stat(1, "restart", 32'h105);
    chk("cmd axis2", 32'h5, 32'(seen1));
  endtask : s_axes

  task automatic s_host();
    logic [7:0] cs [4];
    cs = '{8'h47, ASQ_CMD_KILL, ASQ_CMD_HALT, ASQ_CMD_QUIT};
    for (int i = 0; i < 4; i++) begin
      cmd(1, ASQ_CMD_EVENT, 6);
      cmd(1, cs[i], 16'h1234);
      stat(1, "stopped", 32'h0);
      chk("estop", 32'(cs[i] == ASQ_CMD_KILL), 32'(estop_o[1]));
      chk("host code", 32'(cs[i]), 32'(host_cmd_code_o));
      chk("host value", 32'h1234, 32'(host_cmd_value_o));
      chk("host count", 32'(i + 1), 32'(nhost));
    end
  endtask : s_host

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    s_regs();
    s_flash();
    s_chain();
    s_axes();
    s_host();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done();
  end
endmodule : asq_tb_top
